/* File: rtl/csf_pkg.sv */
// ----------------------------------------------------------------------
// status register constants and types
// ----------------------------------------------------------------------
package csf_pkg;

  // bit positions inside the status byte
  localparam int CARRY_BIT  = 0;
  localparam int NIB_BIT    = 1;
  localparam int ZERO_BIT   = 2;
  localparam int SLEEP_BIT  = 3;
  localparam int WDOG_BIT   = 4;
  localparam int DBANK_LO   = 5;
  localparam int DBANK_HI   = 6;
  localparam int IBANK_BIT  = 7;

  // reset value: bank bits clear, both cause flags set, alu flags zero
  localparam logic [7:0] STAT_RST     = 8'h18;
  // bits that an instruction or software write may change
  localparam logic [7:0] STAT_WR_MASK = 8'he7;
  // the three alu flags
  localparam logic [7:0] FLAG_MASK    = 8'h07;
  // clear op keeps cause flags and low flags, then sets zero
  localparam logic [7:0] CLR_KEEP     = 8'h1b;
  localparam logic [7:0] CLR_SET      = 8'h04;

  // data bank geometry
  localparam int BANK_BYTES = 128;
  localparam int OFS_W      = 7;
  localparam int ADDR_W     = 9;

  // apb register map (byte addresses)
  localparam int          APB_AW     = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_ADDRS  = 12'h004;
  // field positions in the address view register
  localparam int DIR_POS = 0;
  localparam int IND_POS = 16;

  // alu operations
  typedef enum logic [1:0] {
    ALU_PASS = 2'b00,
    ALU_ADD  = 2'b01,
    ALU_SUB  = 2'b11,
    ALU_AND  = 2'b10
  } csf_alu_op_t;

  // one instruction step from the execution logic
  typedef struct packed {
    logic        dest_wr;
    logic        clear_op;
    logic [2:0]  flag_upd;
    csf_alu_op_t alu_op;
    logic [7:0]  opnd_a;
    logic [7:0]  opnd_b;
    logic [7:0]  wr_data;
  } csf_instr_t;

  // alu answer
  typedef struct packed {
    logic       zero;
    logic       nib;
    logic       carry;
    logic [7:0] result;
  } csf_alu_t;

  // memory address request
  typedef struct packed {
    logic [6:0] dir_ofs;
    logic [7:0] ind_ptr;
  } csf_addr_req_t;

endpackage

/* File: rtl/csf_alu_flags.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// alu result and flag generation
// ----------------------------------------------------------------------
module csf_alu_flags
  import csf_pkg::*;
(
  // operation in
  input  wire csf_instr_t instr,
  // result out
  output csf_alu_t        alu_o
);

  logic [8:0] sum;
  logic [4:0] nsum;

  // subtraction adds the two's complement, so carry means no borrow
  always_comb begin
    sum  = 9'h000;
    nsum = 5'h00;
    alu_o.result = instr.opnd_a;
    case (instr.alu_op)
      ALU_ADD: begin
        sum  = {1'b0, instr.opnd_a} + {1'b0, instr.opnd_b};
        nsum = {1'b0, instr.opnd_a[3:0]} + {1'b0, instr.opnd_b[3:0]};
        alu_o.result = sum[7:0];
      end
      ALU_SUB: begin
        sum  = {1'b0, instr.opnd_a} + {1'b0, ~instr.opnd_b} + 9'h001;
        nsum = {1'b0, instr.opnd_a[3:0]} + {1'b0, ~instr.opnd_b[3:0]} + 5'h01;
        alu_o.result = sum[7:0];
      end
      ALU_AND: alu_o.result = instr.opnd_a & instr.opnd_b;
      default: alu_o.result = instr.opnd_a;
    endcase
    alu_o.carry = sum[8];
    alu_o.nib   = nsum[4];
    alu_o.zero  = (alu_o.result == 8'h00);
  end

endmodule
`default_nettype wire

/* File: rtl/csf_bank_decode.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// data memory bank decode
// ----------------------------------------------------------------------
module csf_bank_decode
  import csf_pkg::*;
(
  // bank select bits
  input  wire logic [1:0]    dir_bank,
  input  wire logic          ind_bank,
  // address request
  input  wire csf_addr_req_t req,
  // full data addresses
  output logic [8:0]         dir_addr,
  output logic [8:0]         ind_addr
);

  // direct picks one of four banks, indirect picks the lower or upper pair
  always_comb begin
    dir_addr = {dir_bank, req.dir_ofs};
    ind_addr = {ind_bank, req.ind_ptr};
  end

endmodule
`default_nettype wire

/* File: rtl/csf_status_reg.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - flag updating instructions ignore written flag bits
// - updated flags come from alu result only
// - reset cause flags never written by instructions
// - any instruction may target this register
// - clear op zeroes banks and sets zero
// - subtraction carries are active low borrows
module csf_status_reg
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // instruction execution side
  input  wire csf_instr_t    instr,
  input  wire csf_addr_req_t addr_req,
  // reset cause events
  input  wire logic          wdt_timeout_evt,
  input  wire logic          sleep_evt,
  input  wire logic          wdt_clear_evt,
  // register and alu outputs
  output logic [7:0]         status_out,
  output logic [7:0]         alu_result,
  output logic [8:0]         dir_addr,
  output logic [8:0]         ind_addr
);

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  alu_res_q;
  logic [8:0]  dir_addr_q;
  logic [8:0]  dir_addr_d;
  logic [8:0]  ind_addr_q;
  logic [8:0]  ind_addr_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        seen_q;
  logic        apb_acc;
  logic        apb_done;
  logic        hit_status;
  logic        hit_addrs;
  logic        apb_wr_st;
  logic [7:0]  wmask;
  csf_alu_t    alu_o;

  // --------------------------------------------------------------------
  // alu and bank decode
  // --------------------------------------------------------------------
  csf_alu_flags u_alu (
    .instr (instr),
    .alu_o (alu_o)
  );

  // decode from the next status so addresses track the registered bits
  csf_bank_decode u_dec (
    .dir_bank (status_d[DBANK_HI:DBANK_LO]),
    .ind_bank (status_d[IBANK_BIT]),
    .req      (addr_req),
    .dir_addr (dir_addr_d),
    .ind_addr (ind_addr_d)
  );

  // --------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------
  // address decode and access phases
  always_comb begin
    hit_status = (paddr == OFS_STATUS);
    hit_addrs  = (paddr == OFS_ADDRS);
    apb_acc    = psel & penable & ~pready_q;      // first access cycle
    apb_done   = psel & penable & pready_q;       // edge where master samples
    apb_wr_st  = apb_done & pwrite & hit_status;
  end

  // answer one cycle into the access phase
  // a registered answer costs one wait state but keeps the bus outputs clean
  always_comb begin
    pready_d  = apb_acc;
    pslverr_d = apb_acc & ~(hit_status | hit_addrs);
    prdata_d  = 32'h0000_0000;
    if (apb_acc & ~pwrite & hit_status) begin
      prdata_d[7:0] = status_q;
    end else if (apb_acc & ~pwrite & hit_addrs) begin
      prdata_d[DIR_POS +: ADDR_W] = dir_addr_q;
      prdata_d[IND_POS +: ADDR_W] = ind_addr_q;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // --------------------------------------------------------------------
  // status register next value
  // --------------------------------------------------------------------
  // software write first, then the instruction, then reset cause events
  always_comb begin
    status_d = status_q;
    wmask    = STAT_WR_MASK;
    if (apb_wr_st) begin
      status_d = (status_d & ~STAT_WR_MASK) | (pwdata[7:0] & STAT_WR_MASK);
    end
    if (instr.clear_op) begin
      status_d = (status_d & CLR_KEEP) | CLR_SET;
    end else begin
      if (instr.dest_wr) begin
        // one flag update blocks all three flag write bits
        if (|instr.flag_upd) begin
          wmask = STAT_WR_MASK & ~FLAG_MASK;
        end
        status_d = (status_d & ~wmask) | (instr.wr_data & wmask);
      end
      // updated flags follow the alu, never the write data
      if (instr.flag_upd[2]) begin
        status_d[ZERO_BIT] = alu_o.zero;
      end
      if (instr.flag_upd[1]) begin
        status_d[NIB_BIT] = alu_o.nib;
      end
      if (instr.flag_upd[0]) begin
        status_d[CARRY_BIT] = alu_o.carry;
      end
    end
    // cause flags move only on hardware events, timeout wins
    if (wdt_clear_evt) begin
      status_d[WDOG_BIT]  = 1'b1;
      status_d[SLEEP_BIT] = 1'b1;
    end
    if (sleep_evt) begin
      status_d[WDOG_BIT]  = 1'b1;
      status_d[SLEEP_BIT] = 1'b0;
    end
    if (wdt_timeout_evt) begin
      status_d[WDOG_BIT] = 1'b0;
    end
  end

  // status, alu result and decoded addresses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_q   <= STAT_RST;
      alu_res_q  <= 8'h00;
      dir_addr_q <= 9'h000;
      ind_addr_q <= 9'h000;
      seen_q     <= 1'b0;
    end else begin
      status_q   <= status_d;
      alu_res_q  <= alu_o.result;
      dir_addr_q <= dir_addr_d;
      ind_addr_q <= ind_addr_d;
      seen_q     <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // every output comes straight from a flip-flop
  assign status_out = status_q;
  assign alu_result = alu_res_q;
  assign dir_addr   = dir_addr_q;
  assign ind_addr   = ind_addr_q;
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // only zero updated: low flags ignore write data and stay
  a_flag_wr_mask: assert property (
    instr.dest_wr && !instr.clear_op && instr.flag_upd == 3'b100
    |=> status_q[1:0] == $past(status_q[1:0])
        && status_q[ZERO_BIT] == $past(alu_o.zero))
    else $error("flag bits took write data");

  // all three flags equal the alu answer
  a_flags_from_alu: assert property (
    !instr.clear_op && instr.flag_upd == 3'b111
    |=> status_q[2:0] == {$past(alu_o.zero), $past(alu_o.nib), $past(alu_o.carry)})
    else $error("flags differ from alu");

  // cause flags hold without hardware events
  a_cause_hold: assert property (
    !wdt_timeout_evt && !sleep_evt && !wdt_clear_evt
    |=> $stable(status_q[WDOG_BIT:SLEEP_BIT]))
    else $error("cause flags changed without event");

  // plain destination write stores every writable bit
  a_dest_data: assert property (
    instr.dest_wr && !instr.clear_op && instr.flag_upd == 3'b000 && !apb_wr_st
    |=> status_q[7:5] == $past(instr.wr_data[7:5])
        && status_q[2:0] == $past(instr.wr_data[2:0]))
    else $error("destination write lost");

  // clear op pattern
  a_clear_op: assert property (
    instr.clear_op
    |=> status_q[7:5] == 3'b000 && status_q[ZERO_BIT]
        && status_q[1:0] == $past(status_q[1:0]))
    else $error("clear op result wrong");

  // subtraction carry is the inverse of a borrow
  a_sub_borrow: assert property (
    instr.alu_op == ALU_SUB
    |-> alu_o.carry == (instr.opnd_a >= instr.opnd_b)
        && alu_o.nib == (instr.opnd_a[3:0] >= instr.opnd_b[3:0]))
    else $error("borrow polarity wrong");

  // decoded banks match the registered bank bits
  a_bank_decode: assert property (
    dir_addr_q[8:7] == status_q[DBANK_HI:DBANK_LO]
    && ind_addr_q[8] == status_q[IBANK_BIT])
    else $error("bank decode mismatch");

  // first cycle after reset shows the reset pattern
  a_reset_vals: assert property (
    !seen_q |-> status_q[7:3] == 5'b00011)
    else $error("reset value wrong");

  // apb answers exactly one cycle into access, for one cycle
  a_apb_answer: assert property (
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  // any flag update with a write: updated flags follow the alu, others hold
  a_flag_any_upd: assert property (
    instr.dest_wr && !instr.clear_op && |instr.flag_upd && !apb_wr_st
    |=> status_q[2:0] == (($past(status_q[2:0]) & ~$past(instr.flag_upd))
        | ({$past(alu_o.zero), $past(alu_o.nib), $past(alu_o.carry)}
           & $past(instr.flag_upd))))
    else $error("flag bits took write data");

  // software write lands on the writable bits when the core is quiet
  a_apb_write: assert property (
    apb_wr_st && !instr.dest_wr && !instr.clear_op && instr.flag_upd == 3'b000
    |=> status_q[7:5] == $past(pwdata[7:5])
        && status_q[2:0] == $past(pwdata[2:0]))
    else $error("register write lost");

  // unmapped addresses answer with an error, mapped ones without
  a_apb_error: assert property (
    psel && penable && !pready_q
    |=> pslverr_q != $past(hit_status || hit_addrs))
    else $error("apb error flag wrong");

  // read data bus stays zero outside a read answer
  a_rdata_quiet: assert property (
    !pready_q |-> prdata_q == 32'h0000_0000)
    else $error("read data outside answer");

  // a timeout event always leaves the expiry flag clear
  a_timeout_flag: assert property (
    wdt_timeout_evt |=> !status_q[WDOG_BIT])
    else $error("timeout flag not cleared");

  // writes to the address view leave the status untouched
  a_view_ro: assert property (
    apb_done && pwrite && hit_addrs && !instr.dest_wr && !instr.clear_op
    && instr.flag_upd == 3'b000 && !wdt_timeout_evt && !sleep_evt && !wdt_clear_evt
    |=> $stable(status_q))
    else $error("address view write changed status");

  // covers for the main scenarios
  c_clear_op: cover property (instr.clear_op ##1 status_q[ZERO_BIT]);
  c_sub_borrow: cover property (instr.alu_op == ALU_SUB && !alu_o.carry);
  c_apb_write: cover property (apb_wr_st);
  c_timeout: cover property (wdt_timeout_evt ##1 !status_q[WDOG_BIT]);
  c_masked_write: cover property (instr.dest_wr && instr.flag_upd == 3'b100);

endmodule
`default_nettype wire

/* File: bench/csf_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// instruction execution partner
// ----------------------------------------------------------------------
module csf_core_model
  import csf_pkg::*;
(
  // clock
  input  wire logic clock,
  // instruction step towards the status register
  output var  csf_instr_t instr
);
  initial instr = '0;

  // one step stands for exactly one cycle, then the core idles
  task automatic exec(input csf_instr_t s);
    @(posedge clock);
    instr <= s;
    @(posedge clock);
    instr <= '0;
  endtask
endmodule
`default_nettype wire

/* File: bench/cpu_status_flag_register_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_status_flag_register_bench
  import csf_pkg::*;
;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic wdt_timeout_evt, sleep_evt, wdt_clear_evt;
  logic [7:0] status_out, alu_result, ex;
  logic [8:0] dir_addr, ind_addr;
  csf_instr_t instr;
  csf_addr_req_t addr_req;
  int fails, tests_run, cyc;
  logic [31:0] tbl [7];

  csf_core_model core (.clock(clock), .instr(instr));
  csf_status_reg dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr(instr), .addr_req(addr_req),
    .wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt),
    .wdt_clear_evt(wdt_clear_evt), .status_out(status_out), .alu_result(alu_result),
    .dir_addr(dir_addr), .ind_addr(ind_addr));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // apb transfer: setup, access, wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ins(input logic dw, cl, input logic [2:0] up, input csf_alu_op_t op,
                     input logic [7:0] a, b, wd);
    core.exec(csf_instr_t'{dw, cl, up, op, a, b, wd});
    @(negedge clock);
  endtask

  // pulse one event input: 0 timeout, 1 sleep, 2 clear
  task automatic ev(input int k);
    @(posedge clock);
    {wdt_timeout_evt, sleep_evt, wdt_clear_evt} <= 3'h4 >> k;
    @(posedge clock);
    {wdt_timeout_evt, sleep_evt, wdt_clear_evt} <= 3'h0;
    @(negedge clock);
  endtask

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {wdt_timeout_evt, sleep_evt, wdt_clear_evt} = 3'h0;
    addr_req = '{dir_ofs: 7'h55, ind_ptr: 8'h9a};
    // op, a, b, flags updated, expected flags z/nib/c, result
    tbl = '{{2'b11, 8'h05, 8'h03, 3'h7, 3'h3, 8'h02}, {2'b11, 8'h03, 8'h05, 3'h7, 3'h0, 8'hfe},
            {2'b11, 8'h10, 8'h01, 3'h7, 3'h1, 8'h0f}, {2'b11, 8'h22, 8'h22, 3'h7, 3'h7, 8'h00},
            {2'b01, 8'hff, 8'h01, 3'h7, 3'h7, 8'h00}, {2'b10, 8'hf0, 8'h0f, 3'h4, 3'h4, 8'h00},
            {2'b01, 8'h08, 8'h08, 3'h2, 3'h2, 8'h10}};
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("reset status", status_out, 8'h18);
    apb(1'b0, 12'h000, 32'h0);
    chk("reset read", rdat, 32'h18);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("cause bits kept", rdat, 32'h18);
    apb(1'b1, 12'h000, 32'hff);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", rerr, 1'b1);
    apb(1'b1, 12'h004, 32'h0);
    chk("view write error", rerr, 1'b0);
    chk("status after ff", status_out, 8'hff);
    ins(1'b1, 1'b0, 3'h0, ALU_PASS, 8'h00, 8'h00, 8'ha5);
    chk("plain dest write", status_out, 8'hbd);
    ins(1'b1, 1'b0, 3'h7, ALU_ADD, 8'h01, 8'h01, 8'h47);
    chk("masked flag write", status_out, 8'h58);
    chk("alu result", alu_result, 8'h02);
    ins(1'b1, 1'b0, 3'h4, ALU_AND, 8'h0f, 8'hf0, 8'h23);
    chk("zero only write", status_out, 8'h3c);
    ex = 8'h3c;
    foreach (tbl[i]) begin
      ins(1'b0, 1'b0, tbl[i][13:11], csf_alu_op_t'(tbl[i][31:30]), tbl[i][29:22],
          tbl[i][21:14], 8'h00);
      ex = (ex & ~{5'h0, tbl[i][13:11]}) | {5'h0, tbl[i][10:8] & tbl[i][13:11]};
      chk("flags", status_out, ex);
      chk("result", alu_result, tbl[i][7:0]);
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, {24'h0, k[0], k[1:0], 5'h00});
      repeat (2) @(negedge clock);
      ex = {k[0], k[1:0], ex[4:3], 3'h0};
      chk("bank bits", status_out, ex);
      chk("direct addr", dir_addr, {k[1:0], 7'h55});
      chk("indirect addr", ind_addr, {k[0], 8'h9a});
      apb(1'b0, 12'h004, 32'h0);
      chk("addr view", rdat, {7'h0, k[0], 8'h9a, 7'h0, k[1:0], 7'h55});
    end
    ins(1'b0, 1'b1, 3'h0, ALU_ADD, 8'h01, 8'h01, 8'h00);
    chk("clear op", status_out, {3'h0, ex[4:3], 1'b1, ex[1:0]});
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("second reset", status_out, 8'h18);
    chk("reset view", dir_addr, 9'h000);
    ev(0);
    chk("timeout event", status_out[4:3], 2'h1);
    ev(1);
    chk("sleep event", status_out[4:3], 2'h2);
    apb(1'b1, 12'h000, 32'h18);
    @(negedge clock);
    chk("cause write ignored", status_out, 8'h10);
    ev(2);
    chk("clear event", status_out, 8'h18);
    results();
  end
endmodule
`default_nettype wire
